// ==== src/pm_event_pkg.sv ====
// Shared constants and types of the power-management event register bank
package pm_event_pkg;
    localparam int          REF_CLK_MHZ       = 200;
    localparam int          DEBOUNCE_MS       = 16;
    localparam int          OVERRIDE_MS       = 4000;
    localparam int          DEBOUNCE_CYCLES   = DEBOUNCE_MS * REF_CLK_MHZ * 1000;
    localparam int          OVERRIDE_CYCLES   = OVERRIDE_MS * REF_CLK_MHZ * 1000;
    localparam int          CNT_W             = 30;
    localparam int          IO_ADDR_W         = 16;
    localparam int          BASE_LSB          = 6;
    localparam logic [5:0]  OFF_STATUS        = 6'h00;
    localparam logic [5:0]  OFF_ENABLE        = 6'h02;
    localparam logic [15:0] STATUS_RESET      = 16'h0000;
    localparam logic [15:0] ENABLE_RESET      = 16'h0000;
    localparam logic [15:0] STATUS_MASK       = 16'h8D31;
    localparam logic [15:0] ENABLE_MASK       = 16'h0521;
    localparam int          BIT_RESUME        = 15;
    localparam int          BIT_OVERRIDE      = 11;
    localparam int          BIT_ALARM         = 10;
    localparam int          BIT_BUTTON        = 8;
    localparam int          BIT_GLOBAL        = 5;
    localparam int          BIT_BUSMASTER     = 4;
    localparam int          BIT_TIMER         = 0;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic resume;
        logic override;
        logic alarm;
        logic button;
        logic global;
        logic busmaster;
        logic timer;
    } pm_set_t;
endpackage : pm_event_pkg

// ==== src/button_debounce.sv ====
// Button debounce and hold-time override detector
`timescale 1ns/1ps
module button_debounce
    import pm_event_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
    parameter int OVR_CYCLES = OVERRIDE_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic button_input_n,
    output logic      press_pulse,
    output logic      hold_pulse
);
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_BOUNCE = 4'b0010,
        ST_HELD   = 4'b0100,
        ST_DONE   = 4'b1000
    } deb_state_t;

    deb_state_t       state_ff;
    deb_state_t       nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             press_ff;
    logic             hold_ff;
    wire              pressed   = ~button_input_n;
    wire              deb_reach = (cnt_ff >= CNT_W'(DEB_CYCLES - 1));
    wire              ovr_reach = (cnt_ff >= CNT_W'(OVR_CYCLES - 1));

    // Count restarts on any bounce, so a chattering contact never gets credit
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + CNT_W'(1);
        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = '0;
                if (pressed) begin
                    nxt_state = ST_BOUNCE;
                end
            end
            ST_BOUNCE: begin
                if (!pressed) begin
                    nxt_state = ST_IDLE;
                end else if (deb_reach) begin
                    nxt_state = ST_HELD;
                end
            end
            ST_HELD: begin
                if (!pressed) begin
                    nxt_state = ST_IDLE;
                end else if (ovr_reach) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_cnt = cnt_ff;
                if (!pressed) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            press_ff <= 1'b0;
            hold_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            press_ff <= (state_ff == ST_BOUNCE) && pressed && deb_reach;
            hold_ff  <= (state_ff == ST_HELD) && pressed && ovr_reach;
        end
    end

    assign press_pulse = press_ff;
    assign hold_pulse  = hold_ff;
endmodule : button_debounce

// ==== src/pm_event_status_enable.sv ====
// Power-management event status and resume/event enable registers
//
// Behaviour
// - Decode I/O window at configured base address
// - Status register at offset 00h, resets zero
// - Resume while sleeping sets bit 15, then on
// - Flags set by hardware, write-one clears
// - Long override hold sets bit 11, soft off
// - Alarm request sets alarm flag bit 10
// - Debounced button press sets bit 8
// - Release write with enable sets bit 5
// - Any bus request sets bit 4
// - Timer bit 23 toggle sets bit 0
// - Timer wrap enable raises control interrupt
// - Enable register at offset 02h, resets zero
// - Alarm enable turns alarm into resume
// - Button enable raises management or control interrupt
// - Button produces a resume event whenever sleeping
// - Global enable raises control interrupt
// - Master gate on button control interrupt
// - Global release raises management interrupt, firmware status
`timescale 1ns/1ps
module pm_event_status_enable
    import pm_event_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
    parameter int OVR_CYCLES = OVERRIDE_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic [31:0] PM_BASE_CFG,
    input  wire logic        PM_IO_ENABLE,
    input  wire logic        IO_RD,
    input  wire logic        IO_WR,
    input  wire logic [1:0]  IO_BE,
    input  wire logic [15:0] IO_ADDR,
    input  wire logic [15:0] IO_WDATA,
    output logic      [15:0] IO_RDATA,
    output logic             IO_HIT,
    input  wire logic        BUTTON_INPUT_N,
    input  wire logic        OVERRIDE_ENABLE,
    input  wire logic        ALARM_IRQ,
    input  wire logic [3:0]  BUS_REQUEST_LINES,
    input  wire logic        PCPCI_HOLD_REQUEST_N,
    input  wire logic        TIMER_MSB,
    input  wire logic        FIRMWARE_RELEASE_WR,
    input  wire logic        GLOBAL_RELEASE_WR,
    input  wire logic        FIRMWARE_STS_ENABLE,
    input  wire logic        CONTROL_IRQ_GATE,
    input  wire logic        SLEEPING,
    output logic             SCI,
    output logic             SYSTEM_MGMT_INTERRUPT_N,
    output logic             FIRMWARE_STS_SET,
    output logic             RESUME_TO_ON,
    output logic             SOFT_OFF
);
    io_req_t     req;
    pm_set_t     set_ev;
    logic [15:0] status_ff;
    logic [15:0] enable_ff;
    logic [15:0] nxt_status;
    logic [15:0] nxt_enable;
    logic [15:0] rdata_ff;
    logic        timer_msb_ff;
    logic        resume_on_ff;
    logic        soft_off_ff;
    logic        smi_n_ff;
    logic        fw_sts_ff;
    logic        press_pulse;
    logic        hold_pulse;

    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    assign req = '{rd: IO_RD, wr: IO_WR, be: IO_BE, addr: IO_ADDR, wdata: IO_WDATA};

    // Base is 64-byte aligned; the window is dead until the space is enabled
    wire base_match = PM_IO_ENABLE &&
                      (req.addr[IO_ADDR_W-1:BASE_LSB] ==
                       PM_BASE_CFG[IO_ADDR_W-1:BASE_LSB]);
    wire sel_status = base_match && (req.addr[5:0] == OFF_STATUS);
    wire sel_enable = base_match && (req.addr[5:0] == OFF_ENABLE);
    wire wr_status  = req.wr && sel_status;
    wire wr_enable  = req.wr && sel_enable;
    wire [15:0] wmask      = lane_mask(req.be);
    wire [15:0] clear_bits = wr_status ? (req.wdata & wmask) : 16'h0000;

    button_debounce #(
        .DEB_CYCLES (DEB_CYCLES),
        .OVR_CYCLES (OVR_CYCLES)
    ) u_debounce (
        .clk            (REF_CLK),
        .rst_n          (RST_N),
        .button_input_n (BUTTON_INPUT_N),
        .press_pulse    (press_pulse),
        .hold_pulse     (hold_pulse)
    );

    wire override_ev = hold_pulse && OVERRIDE_ENABLE;
    wire alarm_rise  = ALARM_IRQ && !status_ff[BIT_ALARM];
    // Button resumes regardless of its enable; alarm only when enabled
    wire resume_src  = press_pulse ||
                       (alarm_rise && enable_ff[BIT_ALARM]);

    assign set_ev.resume    = resume_src && SLEEPING;
    assign set_ev.override  = override_ev;
    assign set_ev.alarm     = ALARM_IRQ;
    assign set_ev.button    = press_pulse;
    assign set_ev.global    = FIRMWARE_RELEASE_WR && enable_ff[BIT_GLOBAL];
    assign set_ev.busmaster = (|BUS_REQUEST_LINES) || !PCPCI_HOLD_REQUEST_N;
    assign set_ev.timer     = TIMER_MSB ^ timer_msb_ff;

    // Set beats a same-cycle clear so no event is lost
    always_comb begin
        nxt_status = status_ff & ~clear_bits;
        if (set_ev.resume)    nxt_status[BIT_RESUME]    = 1'b1;
        if (set_ev.override)  nxt_status[BIT_OVERRIDE]  = 1'b1;
        if (set_ev.alarm)     nxt_status[BIT_ALARM]     = 1'b1;
        if (set_ev.button)    nxt_status[BIT_BUTTON]    = 1'b1;
        if (set_ev.global)    nxt_status[BIT_GLOBAL]    = 1'b1;
        if (set_ev.busmaster) nxt_status[BIT_BUSMASTER] = 1'b1;
        if (set_ev.timer)     nxt_status[BIT_TIMER]     = 1'b1;
        if (set_ev.override)  nxt_status[BIT_BUTTON]    = 1'b0;
        nxt_status = nxt_status & STATUS_MASK;
    end

    assign nxt_enable = wr_enable
                      ? (((enable_ff & ~wmask) | (req.wdata & wmask)) & ENABLE_MASK)
                      : enable_ff;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            status_ff <= STATUS_RESET;
            enable_ff <= ENABLE_RESET;
        end else begin
            status_ff <= nxt_status;
            enable_ff <= nxt_enable;
        end
    end

    // Unmapped reads return zero so the window never drives stale data
    wire [15:0] rd_mux = sel_status ? status_ff :
                         sel_enable ? enable_ff : 16'h0000;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rdata_ff <= 16'h0000;
        end else if (req.rd) begin
            rdata_ff <= rd_mux & wmask;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            // Track the pin in reset so release never shows a false toggle
            timer_msb_ff <= TIMER_MSB;
            resume_on_ff <= 1'b0;
            soft_off_ff  <= 1'b0;
            fw_sts_ff    <= 1'b0;
        end else begin
            timer_msb_ff <= TIMER_MSB;
            resume_on_ff <= set_ev.resume;
            soft_off_ff  <= override_ev;
            fw_sts_ff    <= GLOBAL_RELEASE_WR && FIRMWARE_STS_ENABLE;
        end
    end

    // Button events go to the control interrupt only when the master gate is open
    wire btn_pend = status_ff[BIT_BUTTON] && enable_ff[BIT_BUTTON];
    wire sci_next = (status_ff[BIT_TIMER]  && enable_ff[BIT_TIMER]) ||
                    (status_ff[BIT_GLOBAL] && enable_ff[BIT_GLOBAL]) ||
                    (btn_pend && CONTROL_IRQ_GATE);
    wire smi_next = (btn_pend && !CONTROL_IRQ_GATE) ||
                    GLOBAL_RELEASE_WR;

    logic sci_ff;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sci_ff   <= 1'b0;
            smi_n_ff <= 1'b1;
        end else begin
            sci_ff   <= sci_next;
            smi_n_ff <= !smi_next;
        end
    end

    assign IO_RDATA                = rdata_ff;
    assign IO_HIT                  = sel_status || sel_enable;
    assign SCI                     = sci_ff;
    assign SYSTEM_MGMT_INTERRUPT_N = smi_n_ff;
    assign FIRMWARE_STS_SET        = fw_sts_ff;
    assign RESUME_TO_ON            = resume_on_ff;
    assign SOFT_OFF                = soft_off_ff;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_release_write;
        GLOBAL_RELEASE_WR && FIRMWARE_STS_ENABLE;
    endsequence
    sequence s_fw_answer;
        FIRMWARE_STS_SET && !SYSTEM_MGMT_INTERRUPT_N;
    endsequence

    a_clear_on_one: assert property (wr_status && req.wdata[BIT_BUSMASTER] && req.be[0] &&
        !set_ev.busmaster |=> !status_ff[BIT_BUSMASTER])
        else $error("bus master flag not cleared by write of one");
    a_zero_keeps_flag: assert property (wr_status && !req.wdata[BIT_TIMER] &&
        status_ff[BIT_TIMER] |=> status_ff[BIT_TIMER])
        else $error("write of zero changed a flag");
    a_set_beats_clear: assert property (set_ev.busmaster |=> status_ff[BIT_BUSMASTER])
        else $error("bus request lost against clear");
    a_timer_toggle_flag: assert property ($changed(TIMER_MSB) |=> status_ff[BIT_TIMER])
        else $error("timer toggle did not set wrap flag");
    a_alarm_sets_flag: assert property (ALARM_IRQ |=> status_ff[BIT_ALARM])
        else $error("alarm request did not set flag");
    a_resume_then_on: assert property (set_ev.resume |=>
        status_ff[BIT_RESUME] && RESUME_TO_ON)
        else $error("resume flag or on transition missing");
    a_override_soft_off: assert property (override_ev |=>
        status_ff[BIT_OVERRIDE] && !status_ff[BIT_BUTTON] && SOFT_OFF)
        else $error("override did not reach soft off");
    a_timer_sci: assert property (status_ff[BIT_TIMER] && enable_ff[BIT_TIMER] |=> SCI)
        else $error("timer wrap did not raise control interrupt");
    a_button_gate: assert property (btn_pend && !CONTROL_IRQ_GATE |=>
        !SYSTEM_MGMT_INTERRUPT_N)
        else $error("gated button event did not raise management interrupt");
    a_global_sci: assert property (status_ff[BIT_GLOBAL] && enable_ff[BIT_GLOBAL] |=> SCI)
        else $error("global flag did not raise control interrupt");
    a_release_smi: assert property (s_release_write |=> s_fw_answer)
        else $error("release write not answered");
    a_global_needs_en: assert property (!enable_ff[BIT_GLOBAL] && !status_ff[BIT_GLOBAL] &&
        !wr_enable |=> !status_ff[BIT_GLOBAL])
        else $error("global flag set without enable");
    a_reserved_zero: assert property ((status_ff & ~STATUS_MASK) == 16'h0000 &&
        (enable_ff & ~ENABLE_MASK) == 16'h0000)
        else $error("reserved bit became set");
    a_alarm_resume: assert property (alarm_rise && enable_ff[BIT_ALARM] && SLEEPING
        |=> status_ff[BIT_RESUME] ##0 RESUME_TO_ON)
        else $error("enabled alarm did not resume");
    a_button_resume: assert property (press_pulse && SLEEPING |=> RESUME_TO_ON)
        else $error("button press did not resume");
    a_button_flag: assert property (press_pulse && !override_ev |=>
        status_ff[BIT_BUTTON])
        else $error("debounced press did not set flag");
    a_decode_base: assert property (req.rd && sel_enable |=> IO_RDATA ==
        ($past(enable_ff) & $past(wmask)))
        else $error("enable register read mismatch");
    a_status_read: assert property (req.rd && sel_status |=> IO_RDATA ==
        ($past(status_ff) & $past(wmask)))
        else $error("status register read mismatch");
    a_miss_reads_zero: assert property (req.rd && !sel_status && !sel_enable
        |=> IO_RDATA == 16'h0000)
        else $error("unmapped read returned data");
    a_no_hit_disabled: assert property (!PM_IO_ENABLE |-> !IO_HIT)
        else $error("window hit while disabled");
    a_awake_no_resume: assert property (!SLEEPING |=> !RESUME_TO_ON)
        else $error("resume while awake");
    a_resume_needs_cause: assert property (!press_pulse && !alarm_rise
        |=> !RESUME_TO_ON)
        else $error("resume without a cause");
    a_alarm_no_resume: assert property (alarm_rise && !enable_ff[BIT_ALARM] &&
        !press_pulse |=> !RESUME_TO_ON)
        else $error("disabled alarm caused resume");
    a_soft_needs_enable: assert property (!OVERRIDE_ENABLE |=> !SOFT_OFF)
        else $error("soft off without override enable");
    a_fw_needs_enable: assert property (!FIRMWARE_STS_ENABLE |=> !FIRMWARE_STS_SET)
        else $error("firmware status without enable");
    a_hold_keeps_flag: assert property (status_ff[BIT_OVERRIDE] &&
        !clear_bits[BIT_OVERRIDE] |=> status_ff[BIT_OVERRIDE])
        else $error("override flag lost without clear");
    a_enable_holds: assert property (!wr_enable |=> $stable(enable_ff))
        else $error("enable register changed without write");
    a_write_lands: assert property (wr_enable && req.be == 2'b11 |=>
        enable_ff == ($past(req.wdata) & ENABLE_MASK))
        else $error("enable write did not land");
    a_button_no_sci: assert property (!CONTROL_IRQ_GATE &&
        !(status_ff[BIT_TIMER] && enable_ff[BIT_TIMER]) &&
        !(status_ff[BIT_GLOBAL] && enable_ff[BIT_GLOBAL]) |=> !SCI)
        else $error("control interrupt through closed gate");
    a_sci_quiet: assert property (!enable_ff[BIT_BUTTON] && !enable_ff[BIT_TIMER] &&
        !enable_ff[BIT_GLOBAL] |=> !SCI)
        else $error("control interrupt with all enables off");
    a_smi_release: assert property (GLOBAL_RELEASE_WR |=> !SYSTEM_MGMT_INTERRUPT_N)
        else $error("release write gave no management interrupt");
    a_smi_quiet: assert property (!GLOBAL_RELEASE_WR && !btn_pend
        |=> SYSTEM_MGMT_INTERRUPT_N)
        else $error("management interrupt without a cause");
endmodule : pm_event_status_enable

// ==== bench/pm_host_model.sv ====
// Host software model issuing single-cycle I/O accesses
`timescale 1ns/1ps
module pm_host_model (
    input  wire logic        clk,
    output logic             io_rd,
    output logic             io_wr,
    output logic [1:0]       io_be,
    output logic [15:0]      io_addr,
    output logic [15:0]      io_wdata
);
    initial begin
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_be = 2'b00;
        io_addr = 16'h0000;
        io_wdata = 16'h0000;
    end

    // Idle lanes invert so a stale address or data never looks like a live access
    task automatic idle();
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_be = ~io_be;
        io_addr = ~io_addr;
        io_wdata = ~io_wdata;
    endtask : idle

    task automatic access(input logic wr, input logic [15:0] addr, input logic [1:0] be,
                          input logic [15:0] wdata);
        @(posedge clk);
        #1;
        io_wr = wr;
        io_rd = !wr;
        io_be = be;
        io_addr = addr;
        io_wdata = wdata;
        @(posedge clk);
        #1;
        idle();
    endtask : access
endmodule : pm_host_model

// ==== bench/pm_event_status_enable_bench.sv ====
// Self-checking bench of the power-management event register bank
`timescale 1ns/1ps
module pm_event_status_enable_bench;
    import pm_event_pkg::*;
    localparam int DEB = 8;
    localparam int OVR = 40;
    logic        clk = 1'b0, rst_n = 1'b0, io_en = 1'b1, btn_n = 1'b1, ovr_en = 1'b0;
    logic        alarm = 1'b0, hold_n = 1'b1, tmr = 1'b0, fw_rel = 1'b0, gbl_rel = 1'b0;
    logic        fw_en = 1'b0, gate = 1'b0, sleeping = 1'b0;
    logic [3:0]  bus_req = 4'h0;
    logic [15:0] base = 16'h0000, rnd, en_exp, exp_rd, rdata;
    logic        io_rd, io_wr, hit, sci, smi_n, fw_set, resume, soft_off;
    logic [1:0]  io_be;
    logic [15:0] io_addr, io_wdata;
    logic [15:0] q[$];
    int          mismatches = 0, total_checks = 0, cycles = 0;
    int          resume_cnt = 0, soft_cnt = 0, fw_cnt = 0, smi_cnt = 0, c0, c1;
    int          hit_cnt = 0;

    always #2.5 clk = ~clk;

    pm_host_model i_pm_host_model (.clk(clk), .io_rd(io_rd), .io_wr(io_wr), .io_be(io_be),
        .io_addr(io_addr), .io_wdata(io_wdata));

    pm_event_status_enable #(.DEB_CYCLES(DEB), .OVR_CYCLES(OVR)) i_pm_event_status_enable (
        .REF_CLK(clk), .RST_N(rst_n), .PM_BASE_CFG({16'h0000, base}), .PM_IO_ENABLE(io_en),
        .IO_RD(io_rd), .IO_WR(io_wr), .IO_BE(io_be), .IO_ADDR(io_addr), .IO_WDATA(io_wdata),
        .IO_RDATA(rdata), .IO_HIT(hit), .BUTTON_INPUT_N(btn_n), .OVERRIDE_ENABLE(ovr_en),
        .ALARM_IRQ(alarm), .BUS_REQUEST_LINES(bus_req), .PCPCI_HOLD_REQUEST_N(hold_n),
        .TIMER_MSB(tmr), .FIRMWARE_RELEASE_WR(fw_rel), .GLOBAL_RELEASE_WR(gbl_rel),
        .FIRMWARE_STS_ENABLE(fw_en), .CONTROL_IRQ_GATE(gate), .SLEEPING(sleeping),
        .SCI(sci), .SYSTEM_MGMT_INTERRUPT_N(smi_n), .FIRMWARE_STS_SET(fw_set),
        .RESUME_TO_ON(resume), .SOFT_OFF(soft_off));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic wr(input logic [5:0] off, input logic [15:0] d, input logic [1:0] be = 2'b11);
        i_pm_host_model.access(1'b1, base + {10'h000, off}, be, d);
    endtask : wr

    // Expected read data is noted before the strobe; the monitor pops it
    task automatic rd(input logic [5:0] off, input logic [15:0] exp);
        q.push_back(exp);
        i_pm_host_model.access(1'b0, base + {10'h000, off}, 2'b11, 16'h0000);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic press(input int n);
        btn_n = 1'b0;
        cyc(n);
        btn_n = 1'b1;
        cyc(3);
    endtask : press

    always @(posedge clk) begin
        if (io_rd === 1'b1) begin
            #2;
            exp_rd = q.pop_front();
            check("read data", exp_rd, rdata);
        end
    end

    always @(posedge clk) begin
        resume_cnt <= resume_cnt + (resume === 1'b1);
        soft_cnt <= soft_cnt + (soft_off === 1'b1);
        fw_cnt <= fw_cnt + (fw_set === 1'b1);
        smi_cnt <= smi_cnt + (smi_n === 1'b0);
        hit_cnt <= hit_cnt + (((io_rd === 1'b1) || (io_wr === 1'b1)) && (hit === 1'b1));
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h66F5152F));
        base = 16'($urandom()) & 16'hFFC0;
        cyc(2);
        rst_n = 1'b1;
        rd(OFF_STATUS, 16'h0000);
        rd(OFF_ENABLE, 16'h0000);
        rnd = 16'($urandom());
        wr(OFF_ENABLE, rnd);
        rd(OFF_ENABLE, rnd & 16'h0521);
        wr(OFF_ENABLE, 16'hFFFF, 2'b10);
        en_exp = (rnd & 16'h0021) | 16'h0500;
        rd(OFF_ENABLE, en_exp);
        c0 = hit_cnt;
        rd(6'h04, 16'h0000);
        io_en = 1'b0;
        wr(OFF_ENABLE, 16'h0000);
        rd(OFF_ENABLE, 16'h0000);
        io_en = 1'b1;
        rd(OFF_ENABLE, en_exp);
        check("io hits", 16'h0001, 16'(hit_cnt - c0));
        wr(OFF_ENABLE, 16'h0001);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            if (i < 4)
                bus_req[i] = 1'b1;
            else
                hold_n = 1'b0;
            cyc(1);
            bus_req = 4'h0;
            hold_n = 1'b1;
            cyc(2);
            rd(OFF_STATUS, 16'h0010);
            wr(OFF_STATUS, 16'hFFEF);
            rd(OFF_STATUS, 16'h0010);
            wr(OFF_STATUS, 16'h0010);
            rd(OFF_STATUS, 16'h0000);
        end
        bus_req = 4'h1;
        wr(OFF_STATUS, 16'h0010);
        bus_req = 4'h0;
        rd(OFF_STATUS, 16'h0010);
        wr(OFF_STATUS, 16'h0010);
        tmr = ~tmr;
        cyc(3);
        check("sci", 16'h0001, {15'h0, sci});
        rd(OFF_STATUS, 16'h0001);
        wr(OFF_STATUS, 16'h0001);
        cyc(2);
        check("sci", 16'h0000, {15'h0, sci});
        $display("test bus master and timer done");
        sleeping = 1'b1;
        for (int e = 0; e < 2; e++) begin
            wr(OFF_ENABLE, e ? 16'h0400 : 16'h0000);
            c0 = resume_cnt;
            alarm = 1'b1;
            cyc(3);
            alarm = 1'b0;
            rd(OFF_STATUS, e ? 16'h8400 : 16'h0400);
            cyc(2);
            check("resume pulses", 16'(e), 16'(resume_cnt - c0));
            wr(OFF_STATUS, 16'h8400);
        end
        wr(OFF_ENABLE, 16'h0000);
        fw_rel = 1'b1;
        cyc(1);
        fw_rel = 1'b0;
        rd(OFF_STATUS, 16'h0000);
        wr(OFF_ENABLE, 16'h0020);
        fw_rel = 1'b1;
        cyc(1);
        fw_rel = 1'b0;
        cyc(2);
        check("sci", 16'h0001, {15'h0, sci});
        rd(OFF_STATUS, 16'h0020);
        wr(OFF_STATUS, 16'h0020);
        wr(OFF_ENABLE, 16'h0000);
        fw_en = 1'b1;
        c0 = fw_cnt;
        c1 = smi_cnt;
        gbl_rel = 1'b1;
        cyc(1);
        gbl_rel = 1'b0;
        cyc(3);
        check("firmware status pulses", 16'h0001, 16'(fw_cnt - c0));
        check("management interrupt cycles", 16'h0001, 16'(smi_cnt - c1));
        $display("test alarm and release done");
        press(4);
        rd(OFF_STATUS, 16'h0000);
        c0 = resume_cnt;
        press(DEB + 8);
        rd(OFF_STATUS, 16'h8100);
        check("resume pulses", 16'h0001, 16'(resume_cnt - c0));
        check("sci", 16'h0000, {15'h0, sci});
        wr(OFF_ENABLE, 16'h0100);
        gate = 1'b1;
        cyc(2);
        check("sci", 16'h0001, {15'h0, sci});
        gate = 1'b0;
        cyc(2);
        check("sci", 16'h0000, {15'h0, sci});
        check("smi", 16'h0000, {15'h0, smi_n});
        wr(OFF_STATUS, 16'h8100);
        wr(OFF_ENABLE, 16'h0000);
        sleeping = 1'b0;
        ovr_en = 1'b1;
        c0 = soft_cnt;
        press(OVR + 20);
        rd(OFF_STATUS, 16'h0800);
        check("soft off pulses", 16'h0001, 16'(soft_cnt - c0));
        $display("test button done");
        cyc(4);
        final_report();
    end
endmodule : pm_event_status_enable_bench
